// file: src/mscl_top.sv
// Motion start command decoder with AHB-Lite configuration registers.
//
// What this block does
// - Host sets data select first; indexed start edge moves to that entry.
// - Alarm enable bit, default 0, flags positioning starts without origin set.
// - Each sequential start edge moves to the next data number.
// - Each direct start input launches positioning with its own data number.
// - Direct data numbers are 0 to 63, defaulting to 0 through 5.
// - Homing request starts homing; completion with motion stopped sets origin found.
// - Homing mode: 0 is 2-sensor, 1 is 3-sensor, default 1.
// - Homing run speed 1 to 1000000 Hz, default 1000.
// - Homing acceleration 1 to 1000000, default 30000.
// - Homing starting speed 1 to 1000000 Hz, default 100.
// - Signed 24-bit homing offset, default 0.
// - Homing direction: 0 negative, 1 positive, default positive.
// - Slit and phase timing enables during homing, both default 0.
// - 2-sensor back-off steps 1 to 32767, default 200.
// - Positive run input runs positive, negative run input runs negative.
// - Run continues only while its input stays on, else decelerate.
// - Same-direction input during deceleration resumes running.
// - Both run inputs on together decelerate to stop.
// - Data number change during running changes speed immediately.
// - Six select inputs form data number, highest input most significant.
`timescale 1ns/1ps
module mscl_top
  import mscl_pkg::*;
#(
  parameter int unsigned DATA_ENTRIES = 64
) (
  input  wire logic                         clk_sys_i,
  input  wire logic                         reset_n_i,
  input  wire logic                         hsel_i,
  input  wire logic [31:0]                  haddr_i,
  input  wire logic [1:0]                   htrans_i,
  input  wire logic                         hwrite_i,
  input  wire logic [2:0]                   hsize_i,
  input  wire logic [31:0]                  hwdata_i,
  input  wire logic                         hready_i,
  output logic      [31:0]                  hrdata_o,
  output logic                              hreadyout_o,
  output logic                              hresp_o,
  input  wire logic                         start_i,
  input  wire logic                         sequential_start_i,
  input  wire logic [DIRECT_INPUTS-1:0]     direct_start_inputs_i,
  input  wire logic                         home_i,
  input  wire logic                         positive_run_input_i,
  input  wire logic                         negative_run_input_i,
  input  wire logic [DATA_NUM_W-1:0]        data_select_inputs_i,
  input  wire logic                         motion_stopped_i,
  input  wire logic                         homing_done_i,
  output mscl_pkg::mscl_cmd_s               cmd_o,
  output mscl_pkg::mscl_home_s              home_cfg_o,
  output logic                              origin_found_o,
  output logic                              origin_alarm_o
);

  import mscl_pkg::*;

  localparam logic [DATA_NUM_W-1:0] LAST_ENTRY = DATA_NUM_W'(DATA_ENTRIES - 1);

  // Clamps a speed or acceleration write into 1 .. 1000000.
  function automatic logic [19:0] clamp_rate(input logic [31:0] v);
    if (v < 32'(RATE_MIN))
      clamp_rate = RATE_MIN;
    else if (v > 32'(RATE_MAX))
      clamp_rate = RATE_MAX;
    else
      clamp_rate = v[19:0];
  endfunction

  // Bus address phase capture.
  logic        wr_pend_q;
  logic [7:0]  addr_q;
  logic        acc_valid;

  assign acc_valid   = hsel_i && hready_i && htrans_i[1];
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wr_pend_q <= 1'b0;
      addr_q    <= 8'h00;
    end
    else
    begin
      wr_pend_q <= acc_valid && hwrite_i;
      if (acc_valid)
      begin
        addr_q <= haddr_i[7:0];
      end
    end
  end

  // Configuration registers.
  logic [4:0]                      cfg_q;
  logic [DATA_NUM_W-1:0]           direct_num_q [DIRECT_INPUTS];
  logic [19:0]                     home_speed_q;
  logic [19:0]                     home_accel_q;
  logic [19:0]                     home_start_q;
  logic [23:0]                     home_offs_q;
  logic [14:0]                     home_back_q;
  logic                            alarm_clr;

  assign alarm_clr = wr_pend_q && addr_q == CMD_OFS && hwdata_i[CMD_ALARM_CLR_BIT];

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cfg_q        <= CFG_RST;
      home_speed_q <= HOME_SPEED_RST;
      home_accel_q <= HOME_ACCEL_RST;
      home_start_q <= HOME_START_RST;
      home_offs_q  <= HOME_OFFS_RST;
      home_back_q  <= HOME_BACK_RST;
    end
    else if (wr_pend_q)
    begin
      if (addr_q == CFG_OFS)
        cfg_q <= hwdata_i[4:0];
      else if (addr_q == HOME_SPEED_OFS)
        home_speed_q <= clamp_rate(hwdata_i);
      else if (addr_q == HOME_ACCEL_OFS)
        home_accel_q <= clamp_rate(hwdata_i);
      else if (addr_q == HOME_START_OFS)
        home_start_q <= clamp_rate(hwdata_i);
      else if (addr_q == HOME_OFFS_OFS)
        home_offs_q <= hwdata_i[23:0];
      else if (addr_q == HOME_BACK_OFS)
        home_back_q <= (hwdata_i[14:0] == 15'h0000) ? BACK_MIN : hwdata_i[14:0];
    end
  end

  // Direct data numbers: one per byte, inputs 0 to 3 in the low word, 4 and 5 in the high word.
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      for (int i = 0; i < DIRECT_INPUTS; i++)
        direct_num_q[i] <= DIRECT_NUM_RST[i*DIRECT_FIELD_W +: DATA_NUM_W];
    end
    else if (wr_pend_q && addr_q == DIRECT_NUM_OFS)
    begin
      for (int i = 0; i < DIRECT_PER_WORD; i++)
        direct_num_q[i] <= hwdata_i[i*DIRECT_FIELD_W +: DATA_NUM_W];
    end
    else if (wr_pend_q && addr_q == DIRECT_HI_OFS)
    begin
      for (int i = DIRECT_PER_WORD; i < DIRECT_INPUTS; i++)
        direct_num_q[i] <= hwdata_i[(i-DIRECT_PER_WORD)*DIRECT_FIELD_W +: DATA_NUM_W];
    end
  end

  // Start-type edges.
  logic [DIRECT_INPUTS+2:0] start_lvl;
  logic [DIRECT_INPUTS+2:0] start_rise;
  logic                     start_rise_idx;
  logic                     start_rise_seq;
  logic                     start_rise_home;
  logic [DIRECT_INPUTS-1:0] start_rise_dir;

  assign start_lvl = {home_i, sequential_start_i, start_i, direct_start_inputs_i};

  mscl_edge #(
    .W (DIRECT_INPUTS + 3)
  ) u_edge (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .level_i   (start_lvl),
    .rise_o    (start_rise)
  );

  assign start_rise_dir  = start_rise[DIRECT_INPUTS-1:0];
  assign start_rise_idx  = start_rise[DIRECT_INPUTS];
  assign start_rise_seq  = start_rise[DIRECT_INPUTS+1];
  assign start_rise_home = start_rise[DIRECT_INPUTS+2];

  // Lowest-numbered direct input wins when several rise together.
  logic                  dir_hit;
  logic [DATA_NUM_W-1:0] dir_num;

  always_comb
  begin
    dir_hit = 1'b0;
    dir_num = '0;
    for (int i = DIRECT_INPUTS - 1; i >= 0; i--)
    begin
      if (start_rise_dir[i])
      begin
        dir_hit = 1'b1;
        dir_num = direct_num_q[i];
      end
    end
  end

  // Motion state.
  mscl_state_e           state_q;
  logic [DATA_NUM_W-1:0] seq_num_q;
  logic                  run_pos_q;
  logic [DATA_NUM_W-1:0] seq_next;
  logic [DATA_NUM_W-1:0] launch_num;
  logic                  pos_req;
  logic                  run_fwd;
  logic                  run_rev;
  logic                  run_same;
  logic                  idle_now;

  assign pos_req  = start_rise_idx || start_rise_seq || dir_hit;
  assign run_fwd  = positive_run_input_i && !negative_run_input_i;
  assign run_rev  = negative_run_input_i && !positive_run_input_i;
  assign run_same = run_pos_q ? run_fwd : run_rev;
  assign idle_now = state_q == MSCL_IDLE;
  assign seq_next = (seq_num_q == LAST_ENTRY) ? '0 : seq_num_q + 1'b1;

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_q   <= MSCL_IDLE;
      run_pos_q <= 1'b1;
    end
    else
    begin
      case (state_q)
        MSCL_IDLE:
        begin
          if (start_rise_home)
            state_q <= MSCL_HOMING;
          else if (pos_req)
            state_q <= MSCL_POS;
          else if (run_fwd || run_rev)
          begin
            state_q   <= MSCL_RUN;
            run_pos_q <= run_fwd;
          end
        end
        MSCL_POS:
        begin
          if (motion_stopped_i)
            state_q <= MSCL_IDLE;
        end
        MSCL_RUN:
        begin
          if (!run_same)
            state_q <= MSCL_DECEL;
        end
        MSCL_DECEL:
        begin
          if (run_same)
            state_q <= MSCL_RUN;
          else if (motion_stopped_i)
            state_q <= MSCL_IDLE;
        end
        MSCL_HOMING:
        begin
          if (homing_done_i && motion_stopped_i)
            state_q <= MSCL_IDLE;
        end
        default:
        begin
          state_q <= MSCL_IDLE;
        end
      endcase
    end
  end

  // Sequential pointer follows the last positioning entry, wrapping after the table end.
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      seq_num_q <= '0;
    end
    else if (idle_now && !start_rise_home && pos_req)
    begin
      seq_num_q <= launch_num;
    end
  end

  // Command outputs.
  always_comb
  begin
    if (dir_hit)
      launch_num = dir_num;
    else if (start_rise_idx)
      launch_num = data_select_inputs_i;
    else
      launch_num = seq_next;
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cmd_o <= '0;
    end
    else
    begin
      cmd_o.pos_start    <= idle_now && !start_rise_home && pos_req;
      cmd_o.home_start   <= idle_now && start_rise_home;
      cmd_o.run_active   <= state_q == MSCL_RUN;
      cmd_o.run_positive <= run_pos_q;
      if (idle_now && !start_rise_home && pos_req)
        cmd_o.data_num <= launch_num;
      else if (state_q == MSCL_RUN || (idle_now && (run_fwd || run_rev)))
        cmd_o.data_num <= data_select_inputs_i;
    end
  end

  // Origin and alarm.
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      origin_found_o <= 1'b0;
    end
    else if (idle_now && start_rise_home)
    begin
      origin_found_o <= 1'b0;
    end
    else if (state_q == MSCL_HOMING && homing_done_i && motion_stopped_i)
    begin
      origin_found_o <= 1'b1;
    end
  end

  // A new start wins over a clear in the same cycle.
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      origin_alarm_o <= 1'b0;
    end
    else if (cfg_q[CFG_ALARM_EN_BIT] && !origin_found_o && idle_now && !start_rise_home && pos_req)
    begin
      origin_alarm_o <= 1'b1;
    end
    else if (alarm_clr)
    begin
      origin_alarm_o <= 1'b0;
    end
  end

  always_comb
  begin
    home_cfg_o.three_sensor   = cfg_q[CFG_HOME_MODE_BIT];
    home_cfg_o.positive_first = cfg_q[CFG_HOME_DIR_BIT];
    home_cfg_o.slit_en        = cfg_q[CFG_SLIT_EN_BIT];
    home_cfg_o.phase_en       = cfg_q[CFG_PHASE_EN_BIT];
    home_cfg_o.speed_hz       = home_speed_q;
    home_cfg_o.accel          = home_accel_q;
    home_cfg_o.start_hz       = home_start_q;
    home_cfg_o.offset         = home_offs_q;
    home_cfg_o.back_steps     = home_back_q;
  end

  // Read data, decoded from the address phase and registered at its end.
  logic [31:0] rd_word;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (haddr_i[7:0] == CFG_OFS)
      rd_word = {27'h0, cfg_q};
    else if (haddr_i[7:0] == DIRECT_NUM_OFS)
      for (int i = 0; i < DIRECT_PER_WORD; i++)
        rd_word[i*DIRECT_FIELD_W +: DATA_NUM_W] = direct_num_q[i];
    else if (haddr_i[7:0] == DIRECT_HI_OFS)
      for (int i = DIRECT_PER_WORD; i < DIRECT_INPUTS; i++)
        rd_word[(i-DIRECT_PER_WORD)*DIRECT_FIELD_W +: DATA_NUM_W] = direct_num_q[i];
    else if (haddr_i[7:0] == HOME_SPEED_OFS)
      rd_word = {12'h0, home_speed_q};
    else if (haddr_i[7:0] == HOME_ACCEL_OFS)
      rd_word = {12'h0, home_accel_q};
    else if (haddr_i[7:0] == HOME_START_OFS)
      rd_word = {12'h0, home_start_q};
    else if (haddr_i[7:0] == HOME_OFFS_OFS)
      rd_word = {{8{home_offs_q[23]}}, home_offs_q};
    else if (haddr_i[7:0] == HOME_BACK_OFS)
      rd_word = {17'h0, home_back_q};
    else if (haddr_i[7:0] == STATUS_OFS)
      rd_word = {25'h0, state_q, 1'b0, state_q == MSCL_HOMING, origin_alarm_o, origin_found_o};
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      hrdata_o <= 32'h0000_0000;
    else if (acc_valid && !hwrite_i)
      hrdata_o <= rd_word;
  end

  // Checks.
  property p_alarm_on_start;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (cfg_q[CFG_ALARM_EN_BIT] && !origin_found_o && idle_now && !start_rise_home && pos_req) |=> origin_alarm_o;
  endproperty
  a_alarm_on_start: assert property (p_alarm_on_start) else $error("alarm missing after early start");

  property p_no_alarm_disabled;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (!cfg_q[CFG_ALARM_EN_BIT] && !origin_alarm_o) |=> !origin_alarm_o;
  endproperty
  a_no_alarm_disabled: assert property (p_no_alarm_disabled) else $error("alarm raised while disabled");

  property p_index_num;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (idle_now && start_rise_idx && !dir_hit && !start_rise_home)
      |=> cmd_o.pos_start && cmd_o.data_num == $past(data_select_inputs_i);
  endproperty
  a_index_num: assert property (p_index_num) else $error("indexed start used wrong number");

  property p_direct_num;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (idle_now && start_rise_dir[0] && !start_rise_home) |=> cmd_o.data_num == $past(direct_num_q[0]);
  endproperty
  a_direct_num: assert property (p_direct_num) else $error("direct start used wrong number");

  property p_seq_next;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (idle_now && start_rise_seq && !start_rise_idx && !dir_hit && !start_rise_home)
      |=> seq_num_q == DATA_NUM_W'($past(seq_num_q) + 1'b1);
  endproperty
  a_seq_next: assert property (p_seq_next) else $error("sequential pointer did not advance");

  property p_origin_set;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (state_q == MSCL_HOMING && homing_done_i && motion_stopped_i) |=> origin_found_o && idle_now;
  endproperty
  a_origin_set: assert property (p_origin_set) else $error("origin not flagged after homing");

  property p_both_decel;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (state_q == MSCL_RUN && positive_run_input_i && negative_run_input_i) |=> state_q == MSCL_DECEL;
  endproperty
  a_both_decel: assert property (p_both_decel) else $error("both run inputs did not decelerate");

  property p_resume;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (state_q == MSCL_DECEL && run_same) |=> state_q == MSCL_RUN ##1 cmd_o.run_active;
  endproperty
  a_resume: assert property (p_resume) else $error("run did not resume from deceleration");

  property p_speed_follow;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (state_q == MSCL_RUN) |=> cmd_o.data_num == $past(data_select_inputs_i);
  endproperty
  a_speed_follow: assert property (p_speed_follow) else $error("run entry not followed");

  property p_held_no_retrigger;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (start_i && $past(start_i) && !sequential_start_i && direct_start_inputs_i == '0) |-> !pos_req;
  endproperty
  a_held_no_retrigger: assert property (p_held_no_retrigger) else $error("held start retriggered");

endmodule

// file: shared/mscl_pkg.sv
// Package holding constants, register map and types of the motion start command logic.
package mscl_pkg;

  localparam int unsigned DATA_NUM_W     = 6;
  localparam int unsigned DIRECT_INPUTS  = 6;

  // Six 6-bit numbers do not fit one 32-bit word, so they sit one to a byte, four to a word.
  localparam int unsigned DIRECT_FIELD_W  = 8;
  localparam int unsigned DIRECT_PER_WORD = 4;

  // Register byte offsets.
  localparam logic [7:0] CFG_OFS        = 8'h00;
  localparam logic [7:0] DIRECT_NUM_OFS = 8'h04;
  localparam logic [7:0] HOME_SPEED_OFS = 8'h08;
  localparam logic [7:0] HOME_ACCEL_OFS = 8'h0c;
  localparam logic [7:0] HOME_START_OFS = 8'h10;
  localparam logic [7:0] HOME_OFFS_OFS  = 8'h14;
  localparam logic [7:0] HOME_BACK_OFS  = 8'h18;
  localparam logic [7:0] STATUS_OFS     = 8'h1c;
  localparam logic [7:0] CMD_OFS        = 8'h20;
  localparam logic [7:0] DIRECT_HI_OFS  = 8'h24;

  // Configuration register field positions.
  localparam int unsigned CFG_ALARM_EN_BIT  = 0;
  localparam int unsigned CFG_HOME_MODE_BIT = 1;
  localparam int unsigned CFG_HOME_DIR_BIT  = 2;
  localparam int unsigned CFG_SLIT_EN_BIT   = 3;
  localparam int unsigned CFG_PHASE_EN_BIT  = 4;

  // Status register field positions.
  localparam int unsigned ST_ORIGIN_BIT  = 0;
  localparam int unsigned ST_ALARM_BIT   = 1;
  localparam int unsigned ST_HOMING_BIT  = 2;
  localparam int unsigned ST_STATE_LSB   = 4;

  // Command register: writing one here clears the origin-missing alarm.
  localparam int unsigned CMD_ALARM_CLR_BIT = 0;

  // Reset values.
  localparam logic [4:0]  CFG_RST        = 5'h06;
  localparam logic [47:0] DIRECT_NUM_RST = 48'h05_04_03_02_01_00;
  localparam logic [19:0] HOME_SPEED_RST = 20'h003e8;
  localparam logic [19:0] HOME_ACCEL_RST = 20'h07530;
  localparam logic [19:0] HOME_START_RST = 20'h00064;
  localparam logic [23:0] HOME_OFFS_RST  = 24'h000000;
  localparam logic [14:0] HOME_BACK_RST  = 15'h00c8;

  // Limits of the speed, acceleration and back-off step settings.
  localparam logic [19:0] RATE_MIN = 20'h00001;
  localparam logic [19:0] RATE_MAX = 20'hf4240;
  localparam logic [14:0] BACK_MIN = 15'h0001;

  typedef enum logic [2:0] {
    MSCL_IDLE   = 3'b000,
    MSCL_POS    = 3'b001,
    MSCL_RUN    = 3'b011,
    MSCL_DECEL  = 3'b010,
    MSCL_HOMING = 3'b110
  } mscl_state_e;

  // Operation request handed to the profile generator.
  typedef struct packed {
    logic                  pos_start;
    logic                  run_active;
    logic                  run_positive;
    logic                  home_start;
    logic [DATA_NUM_W-1:0] data_num;
  } mscl_cmd_s;

  // Homing parameters handed to the homing sequencer.
  typedef struct packed {
    logic        three_sensor;
    logic        positive_first;
    logic        slit_en;
    logic        phase_en;
    logic [19:0] speed_hz;
    logic [19:0] accel;
    logic [19:0] start_hz;
    logic [23:0] offset;
    logic [14:0] back_steps;
  } mscl_home_s;

endpackage

// file: src/mscl_edge.sv
// Rising-edge detector for the start-type command inputs.
`timescale 1ns/1ps
module mscl_edge #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_sys_i,
  input  wire logic         reset_n_i,
  input  wire logic [W-1:0] level_i,
  output logic      [W-1:0] rise_o
);

  logic [W-1:0] prev_q;

  // Inputs held on through reset do not fire once reset is released.
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      prev_q <= '1;
    end
    else
    begin
      prev_q <= level_i;
    end
  end

  assign rise_o = level_i & ~prev_q;

endmodule

// file: tb/mscl_motion_model.sv
// Behavioural motion generator and homing sequencer seen by the command logic.
`timescale 1ns/1ps
module mscl_motion_model
  import mscl_pkg::*;
#(
  parameter int unsigned LAG = 12
) (
  input  wire logic                clk_sys_i,
  input  wire logic                reset_n_i,
  input  mscl_pkg::mscl_cmd_s      cmd_i,
  output logic                     motion_stopped_o,
  output logic                     homing_done_o
);
  int unsigned cnt_q;
  logic        hom_q;
  logic        run_q;

  // A falling run level starts a deceleration that takes LAG cycles to finish.
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cnt_q <= 0;
      hom_q <= 1'b0;
      run_q <= 1'b0;
      homing_done_o <= 1'b0;
    end
    else
    begin
      homing_done_o <= 1'b0;
      run_q <= cmd_i.run_active;
      if (cmd_i.pos_start || cmd_i.home_start || (run_q && !cmd_i.run_active))
      begin
        cnt_q <= LAG;
        hom_q <= hom_q | cmd_i.home_start;
      end
      else if (cnt_q != 0)
        cnt_q <= cnt_q - 1;
      else if (hom_q)
      begin
        hom_q <= 1'b0;
        homing_done_o <= 1'b1;
      end
    end
  end

  // The delayed run level covers the cycle before the deceleration count is loaded.
  assign motion_stopped_o = !cmd_i.run_active && !run_q && !cmd_i.pos_start && !cmd_i.home_start &&
    cnt_q == 0 && !hom_q;
endmodule

// file: tb/mscl_top_tb.sv
// Self-checking testbench of the motion start command logic.
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; $display("BAD %0t got %h want %h", $time, (a), (b)); end end
`define WAITC(c) begin int n_; n_ = 0; while (!(c) && n_ < 300) begin @(posedge clk_sys_i); n_++; end if (!(c)) begin err_total++; summarize(); end end
module mscl_top_tb;
  import mscl_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic [8:0]  go = 9'h0;
  logic        positive_run_input = 1'b0;
  logic        negative_run_input = 1'b0;
  logic [5:0]  sel = 6'h0;
  logic        stopped;
  logic        hdone;
  logic        org;
  logic        alm;
  mscl_cmd_s   cmd;
  mscl_home_s  hcfg;
  int          err_total = 0;
  int          num_checks = 0;
  int          pos_cnt = 0;
  int          home_cnt = 0;
  logic [5:0]  last_num;
  logic [7:0]  adr [9];
  logic [31:0] exp_v [9];

  always #2 clk_sys_i = ~clk_sys_i;

  mscl_top mscl_top_inst (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout),
    .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(), .start_i(go[0]), .sequential_start_i(go[1]),
    .direct_start_inputs_i(go[8:3]), .home_i(go[2]), .positive_run_input_i(positive_run_input), .negative_run_input_i(negative_run_input),
    .data_select_inputs_i(sel), .motion_stopped_i(stopped), .homing_done_i(hdone), .cmd_o(cmd),
    .home_cfg_o(hcfg), .origin_found_o(org), .origin_alarm_o(alm));

  mscl_motion_model #(.LAG(12)) mscl_motion_model_inst (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .cmd_i(cmd), .motion_stopped_o(stopped), .homing_done_o(hdone));

  always @(posedge clk_sys_i)
  begin
    if (cmd.pos_start === 1'b1)
    begin
      pos_cnt++;
      last_num = cmd.data_num;
    end
    if (cmd.home_start === 1'b1)
      home_cnt++;
  end

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Lets at least one rising edge pass and stops at the first edge that samples ready high.
  task automatic wait_ready();
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 300);
    if (hreadyout !== 1'b1)
    begin
      err_total++;
      summarize();
    end
  endtask

  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_sys_i);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_ready();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(a, 1'b1, d, r);
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(a, 1'b0, 32'h0, r);
    `CHK(r, e)
  endtask

  // Holds the start input for several cycles so a level-sensitive retrigger would show up.
  task automatic pulse(input int k);
    int c0;
    c0 = pos_cnt + home_cnt;
    @(posedge clk_sys_i);
    go[k] <= 1'b1;
    `WAITC(pos_cnt + home_cnt != c0)
    repeat (4) @(posedge clk_sys_i);
    `CHK(pos_cnt + home_cnt, c0 + 1)
    go[k] <= 1'b0;
    `WAITC(stopped === 1'b1)
    repeat (2) @(posedge clk_sys_i);
  endtask

  initial
  begin
    adr = '{CFG_OFS, DIRECT_NUM_OFS, DIRECT_HI_OFS, HOME_SPEED_OFS, HOME_ACCEL_OFS, HOME_START_OFS,
      HOME_OFFS_OFS, HOME_BACK_OFS, 8'h40};
    exp_v = '{32'h6, 32'h0302_0100, 32'h0504, 32'h3e8, 32'h7530, 32'h64, 32'h0, 32'hc8, 32'h0};
    repeat (20) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 9; i++)
      chk_reg(adr[i], exp_v[i]);
    `CHK({hcfg.three_sensor, hcfg.positive_first, hcfg.slit_en, hcfg.phase_en}, 4'hc)
    `CHK({hcfg.speed_hz, hcfg.accel, hcfg.start_hz, hcfg.back_steps}, {20'h3e8, 20'h7530, 20'h64, 15'hc8})
    sel <= 6'h2a;
    pulse(0);
    `CHK(last_num, 6'h2a)
    `CHK({org, alm}, 2'h0)
    pulse(1);
    `CHK(last_num, 6'h2b)
    pulse(1);
    `CHK(last_num, 6'h2c)
    wr(CFG_OFS, 32'h7);
    for (int i = 0; i < 6; i++)
    begin
      pulse(3 + i);
      `CHK(last_num, 6'(i))
    end
    `CHK(alm, 1'b1)
    chk_reg(STATUS_OFS, 32'h2);
    wr(CMD_OFS, 32'h1);
    @(posedge clk_sys_i);
    `CHK(alm, 1'b0)
    wr(DIRECT_NUM_OFS, 32'h0302_013f);
    pulse(3);
    `CHK(last_num, 6'h3f)
    wr(HOME_SPEED_OFS, 32'h0);
    chk_reg(HOME_SPEED_OFS, 32'h1);
    wr(HOME_BACK_OFS, 32'h0);
    chk_reg(HOME_BACK_OFS, 32'h1);
    wr(HOME_OFFS_OFS, 32'h800000);
    chk_reg(HOME_OFFS_OFS, 32'hff800000);
    wr(CFG_OFS, 32'h19);
    @(posedge clk_sys_i);
    `CHK({hcfg.three_sensor, hcfg.positive_first, hcfg.slit_en, hcfg.phase_en, hcfg.offset}, 28'h3800000)
    pulse(2);
    `CHK({home_cnt, org}, {32'd1, 1'b1})
    `CHK(alm, 1'b1)
    wr(CMD_OFS, 32'h1);
    pulse(0);
    `CHK(alm, 1'b0)
    sel <= 6'h3;
    positive_run_input <= 1'b1;
    `WAITC(cmd.run_active === 1'b1)
    `CHK({cmd.run_positive, cmd.data_num}, 7'h43)
    sel <= 6'h9;
    repeat (3) @(posedge clk_sys_i);
    `CHK(cmd.data_num, 6'h9)
    positive_run_input <= 1'b0;
    `WAITC(cmd.run_active === 1'b0)
    `CHK(stopped, 1'b0)
    positive_run_input <= 1'b1;
    `WAITC(cmd.run_active === 1'b1)
    `CHK(cmd.run_active, 1'b1)
    negative_run_input <= 1'b1;
    `WAITC(cmd.run_active === 1'b0)
    `CHK(cmd.run_active, 1'b0)
    positive_run_input <= 1'b0;
    negative_run_input <= 1'b0;
    `WAITC(stopped === 1'b1)
    @(posedge clk_sys_i);
    negative_run_input <= 1'b1;
    `WAITC(cmd.run_active === 1'b1)
    `CHK(cmd.run_positive, 1'b0)
    negative_run_input <= 1'b0;
    `WAITC(stopped === 1'b1)
    summarize();
  end
endmodule
